// File: hdl/smcg_pkg.sv
// Package with constants for the sleep-mode and clock-gating controller.
package smcg_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] SMCG_SLEEP_CTRL_OFS = 8'h00;
    localparam logic [7:0] SMCG_POWER_RED_OFS = 8'h04;
    localparam logic [7:0] SMCG_INPUT_DIS_OFS = 8'h08;
    localparam logic [7:0] SMCG_STATUS_OFS = 8'h0c;
    localparam logic [7:0] SMCG_CONFIG_OFS = 8'h10;
    // Sleep control field positions.
    localparam int SMCG_SE_BIT = 0;
    localparam int SMCG_SM_LSB = 1;
    // Power reduction bit positions.
    localparam int SMCG_PR_CONV = 0;
    localparam int SMCG_PR_SER = 1;
    localparam int SMCG_PR_SPI = 2;
    localparam int SMCG_PR_TMR1 = 3;
    localparam int SMCG_PR_TMR0 = 5;
    localparam int SMCG_PR_TMR2 = 6;
    localparam int SMCG_PR_TWI = 7;
    localparam logic [7:0] SMCG_PR_MASK = 8'hef;
    // Configuration bit positions.
    localparam int SMCG_CF_CONV_EN = 0;
    localparam int SMCG_CF_CMP_DIS = 1;
    localparam int SMCG_CF_CMP_REF = 2;
    localparam int SMCG_CF_WDT_EN = 3;
    localparam int SMCG_CF_T2_ASYNC = 4;
    localparam int SMCG_CF_T2_EN = 5;
    localparam logic [7:0] SMCG_RESET_VAL = 8'h00;
    // Sleep mode encodings.
    localparam logic [2:0] SMCG_SM_IDLE = 3'h0;
    localparam logic [2:0] SMCG_SM_NOISE = 3'h1;
    localparam logic [2:0] SMCG_SM_PDOWN = 3'h2;
    localparam logic [2:0] SMCG_SM_PSAVE = 3'h3;
    localparam logic [2:0] SMCG_SM_STBY = 3'h6;
    localparam logic [2:0] SMCG_SM_XSTBY = 3'h7;
    // Wake timing in clock cycles.
    localparam logic [7:0] SMCG_STBY_WAKE_CYC = 8'h06;
    localparam logic [7:0] SMCG_IRQ_HALT_CYC = 8'h04;
    localparam logic [7:0] SMCG_STARTUP_CYC = 8'h10;
    localparam logic [1:0] SMCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMCG_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SMCG_ST_ACTIVE, SMCG_ST_SLEEP, SMCG_ST_WAKE} smcg_state_t;
endpackage

// File: hdl/smcg_top.sv
// Sleep-mode and clock-gating controller with AXI4-Lite registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module smcg_top (
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read response valid.
    input wire logic s_axi_rready, // Read response ready.
    input wire logic sleep_instr, // Sleep instruction pulse from the core.
    input wire logic global_irq_en, // Global interrupt enable of cpu_status_register.
    input wire logic [2:0] timer2_interrupt_mask, // Timer2 compare B, compare A, overflow enables.
    input wire logic [2:0] timer2_event, // Timer2 event pulses, same order.
    input wire logic ext_wake, // Other enabled wake source, asynchronous.
    input wire logic xtal_option, // Crystal or resonator clock option selected.
    input wire logic [1:0] brownout_level_fuses, // Nonzero enables the brown-out detector.
    input wire logic debug_fuse, // On-chip debug enabled by fuse.
    input wire logic [7:0] wake_pin_need, // Pins needed to sense wake-up.
    output logic cpu_halt, // Core halted.
    output logic cpu_resume, // One-cycle pulse: core resumes.
    output logic clk_cpu_en, // CPU and flash clock enable.
    output logic clk_io_en, // I/O clock enable.
    output logic clk_conv_en, // Converter clock enable.
    output logic main_osc_en, // Main oscillator enable.
    output logic t2_osc_en, // Timer2 asynchronous oscillator enable.
    output logic t2_sync_clk_en, // Synchronous clock to timer2.
    output logic [7:0] periph_clk_en, // Per-peripheral clock enables.
    output logic [7:0] periph_reg_en, // Per-peripheral register access allowed.
    output logic conv_en, // Converter enabled.
    output logic conv_extended, // Next conversion is extended.
    output logic cmp_en, // Analog comparator enabled.
    output logic vref_en, // Internal voltage reference enabled.
    output logic brownout_detector_en, // Brown-out detector enabled.
    output logic wdt_en, // Watchdog enabled.
    output logic [7:0] in_buf_en, // Digital input buffers, port pins.
    output logic [7:0] converter_input_en, // Converter pin digital input enable.
    output logic [1:0] comparator_input_en // Comparator pin digital input enable.
);
    import smcg_pkg::*;

    logic [7:0] sleep_ctrl_reg;
    logic [7:0] power_reduction_register;
    logic [7:0] converter_input_disable;
    logic [1:0] comparator_input_disable;
    logic [7:0] config_reg;
    smcg_state_t state_reg;
    logic [2:0] mode_reg;
    logic [7:0] cnt_reg;
    logic wake_s1_reg;
    logic wake_s2_reg;
    logic conv_was_off_reg;
    logic conv_ext_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == SMCG_SLEEP_CTRL_OFS) || (a == SMCG_POWER_RED_OFS)
            || (a == SMCG_INPUT_DIS_OFS) || (a == SMCG_STATUS_OFS)
            || (a == SMCG_CONFIG_OFS);
    endfunction

    // Standby modes only keep the oscillator when a crystal is fitted.
    function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic x);
        if (m == SMCG_SM_STBY && !x) begin
            eff_mode = SMCG_SM_PDOWN;
        end else if (m == SMCG_SM_XSTBY && !x) begin
            eff_mode = SMCG_SM_PSAVE;
        end else begin
            eff_mode = m;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave. Address and data are captured in either order.
    logic wr_fire;
    logic rd_fire;
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SMCG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_ok({awaddr_reg[7:2], 2'b00}) ? SMCG_RESP_OKAY
                    : SMCG_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    logic [7:0] wa;
    logic wlane;
    assign wa = {awaddr_reg[7:2], 2'b00};
    assign wlane = wr_fire && wstrb_reg[0];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sleep_ctrl_reg <= SMCG_RESET_VAL;
            power_reduction_register <= SMCG_RESET_VAL;
            converter_input_disable <= SMCG_RESET_VAL;
            comparator_input_disable <= 2'b00;
            config_reg <= SMCG_RESET_VAL;
        end else if (wlane) begin
            case (wa)
                SMCG_SLEEP_CTRL_OFS: sleep_ctrl_reg <= {4'h0, wdata_reg[3:0]};
                SMCG_POWER_RED_OFS: power_reduction_register <= wdata_reg[7:0] & SMCG_PR_MASK;
                SMCG_INPUT_DIS_OFS: begin
                    converter_input_disable <= wdata_reg[7:0];
                    if (wstrb_reg[1]) begin
                        comparator_input_disable <= wdata_reg[9:8];
                    end
                end
                SMCG_CONFIG_OFS: config_reg <= {2'b00, wdata_reg[5:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= SMCG_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= addr_ok({s_axi_araddr[7:2], 2'b00}) ? SMCG_RESP_OKAY
                : SMCG_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                SMCG_SLEEP_CTRL_OFS: rdata_reg <= {24'h0, sleep_ctrl_reg};
                SMCG_POWER_RED_OFS: rdata_reg <= {24'h0, power_reduction_register};
                SMCG_INPUT_DIS_OFS: rdata_reg <= {22'h0, comparator_input_disable,
                    converter_input_disable};
                SMCG_STATUS_OFS: rdata_reg <= {20'h0, vref_en, conv_ext_reg, mode_reg,
                    cpu_halt, 6'h00 | {4'h0, state_reg}};
                SMCG_CONFIG_OFS: rdata_reg <= {24'h0, config_reg};
                default: rdata_reg <= 32'h0;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep sequencer.
    logic t2_wake;
    logic [2:0] sel_mode;
    assign sel_mode = eff_mode(sleep_ctrl_reg[SMCG_SM_LSB +: 3], xtal_option);
    // Timer2 wakes the core only in idle, noise, power-save and extended standby.
    assign t2_wake = global_irq_en && |(timer2_interrupt_mask & timer2_event)
        && config_reg[SMCG_CF_T2_EN];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= ext_wake;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    logic wake_any;
    logic t2_mode;
    assign t2_mode = (mode_reg == SMCG_SM_PSAVE) || (mode_reg == SMCG_SM_XSTBY)
        || (mode_reg == SMCG_SM_NOISE) || (mode_reg == SMCG_SM_IDLE);
    assign wake_any = wake_s2_reg || (t2_wake && t2_mode);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= SMCG_ST_ACTIVE;
            mode_reg <= SMCG_SM_IDLE;
            cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                SMCG_ST_ACTIVE: begin
                    // Reserved codes are treated as no sleep at all.
                    if (sleep_instr && sleep_ctrl_reg[SMCG_SE_BIT]
                        && sel_mode != 3'h4 && sel_mode != 3'h5) begin
                        state_reg <= SMCG_ST_SLEEP;
                        mode_reg <= sel_mode;
                    end
                end
                SMCG_ST_SLEEP: begin
                    if (wake_any) begin
                        state_reg <= SMCG_ST_WAKE;
                        if (mode_reg == SMCG_SM_STBY || mode_reg == SMCG_SM_XSTBY) begin
                            cnt_reg <= SMCG_STBY_WAKE_CYC - 8'h01;
                        end else if (mode_reg == SMCG_SM_IDLE || mode_reg == SMCG_SM_NOISE) begin
                            cnt_reg <= SMCG_IRQ_HALT_CYC - 8'h01;
                        end else begin
                            cnt_reg <= SMCG_STARTUP_CYC + SMCG_IRQ_HALT_CYC - 8'h01;
                        end
                    end
                end
                SMCG_ST_WAKE: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= SMCG_ST_ACTIVE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: state_reg <= SMCG_ST_ACTIVE;
            endcase
        end
    end

    assign cpu_halt = state_reg != SMCG_ST_ACTIVE;
    assign cpu_resume = state_reg == SMCG_ST_WAKE && cnt_reg == 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Clock domain enables per sleep mode.
    logic sleeping;
    logic psave_like;
    logic osc_kept;
    assign sleeping = state_reg == SMCG_ST_SLEEP;
    assign psave_like = mode_reg == SMCG_SM_PSAVE || mode_reg == SMCG_SM_XSTBY;
    assign osc_kept = mode_reg == SMCG_SM_STBY || mode_reg == SMCG_SM_XSTBY;

    always_comb begin
        clk_cpu_en = !cpu_halt;
        clk_io_en = !sleeping || mode_reg == SMCG_SM_IDLE;
        clk_conv_en = !sleeping || mode_reg == SMCG_SM_IDLE || mode_reg == SMCG_SM_NOISE;
        // Debug needs the main clock alive even in the deepest modes.
        main_osc_en = !sleeping || mode_reg == SMCG_SM_IDLE || mode_reg == SMCG_SM_NOISE
            || osc_kept || debug_fuse;
        t2_osc_en = config_reg[SMCG_CF_T2_ASYNC] && config_reg[SMCG_CF_T2_EN];
        // In power-save the synchronous source runs only for timer2.
        t2_sync_clk_en = !config_reg[SMCG_CF_T2_ASYNC] && config_reg[SMCG_CF_T2_EN]
            && !power_reduction_register[SMCG_PR_TMR2]
            && (!sleeping || clk_io_en || psave_like);
    end

    // Gated peripherals freeze; clearing the bit resumes them untouched.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pr
            assign periph_clk_en[gi] = !power_reduction_register[gi] && clk_io_en
                && SMCG_PR_MASK[gi];
            assign periph_reg_en[gi] = !power_reduction_register[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Analog support functions.
    logic conv_on;
    assign conv_on = config_reg[SMCG_CF_CONV_EN] && !power_reduction_register[SMCG_PR_CONV];
    assign conv_en = conv_on;
    assign conv_extended = conv_ext_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            conv_was_off_reg <= 1'b1;
            conv_ext_reg <= 1'b1;
        end else begin
            conv_was_off_reg <= !conv_on;
            if (conv_on && conv_was_off_reg) begin
                conv_ext_reg <= 1'b1;
            end else if (conv_on) begin
                conv_ext_reg <= 1'b0;
            end
        end
    end

    assign cmp_en = !config_reg[SMCG_CF_CMP_DIS] && (!sleeping
        || mode_reg == SMCG_SM_IDLE || mode_reg == SMCG_SM_NOISE);
    assign brownout_detector_en = brownout_level_fuses != 2'b00;
    // Reference follows the comparator setup even when sleep turns it off.
    assign vref_en = brownout_detector_en || conv_on || (!config_reg[SMCG_CF_CMP_DIS]
        && config_reg[SMCG_CF_CMP_REF]);
    assign wdt_en = config_reg[SMCG_CF_WDT_EN];
    assign in_buf_en = (clk_io_en || clk_conv_en) ? 8'hff : wake_pin_need;
    assign converter_input_en = ~converter_input_disable;
    assign comparator_input_en = ~comparator_input_disable;

    ////////////////////////////////////////////////////////////////////////////
    a_standby_wake_six: assert property (@(posedge clk_sys) disable iff (srst)
        (sleeping && wake_any && osc_kept) |-> ##6 cpu_resume ##1 !cpu_halt)
        else $error("standby wake not six cycles");
    a_no_sleep_wo_se: assert property (@(posedge clk_sys) disable iff (srst)
        (state_reg == SMCG_ST_ACTIVE && !sleep_ctrl_reg[SMCG_SE_BIT]) |=> !sleeping)
        else $error("sleep without enable bit");
    a_comparator_off_deep: assert property (@(posedge clk_sys) disable iff (srst)
        (sleeping && !clk_conv_en) |-> !cmp_en)
        else $error("comparator on in deep sleep");
    a_pdown_clocks_off: assert property (@(posedge clk_sys) disable iff (srst)
        (sleeping && mode_reg == SMCG_SM_PDOWN && !debug_fuse) |-> !main_osc_en && !clk_io_en)
        else $error("clock running in power-down");
    a_gate_blocks_regs: assert property (@(posedge clk_sys) disable iff (srst)
        power_reduction_register[SMCG_PR_TMR0] |-> !periph_clk_en[SMCG_PR_TMR0]
        && !periph_reg_en[SMCG_PR_TMR0])
        else $error("gated peripheral still clocked");
    a_vref_need: assert property (@(posedge clk_sys) disable iff (srst)
        vref_en |-> (brownout_detector_en || conv_on || cmp_en || config_reg[SMCG_CF_CMP_REF]))
        else $error("reference on without user");
    a_t2_wake_gated: assert property (@(posedge clk_sys) disable iff (srst)
        (sleeping && !global_irq_en && !wake_s2_reg) |=> sleeping)
        else $error("timer2 woke without global enable");
    a_idle_cpu_only: assert property (@(posedge clk_sys) disable iff (srst)
        (sleeping && mode_reg == SMCG_SM_IDLE) |-> !clk_cpu_en && clk_io_en)
        else $error("idle clocks wrong");
    c_enter_psave: cover property (@(posedge clk_sys) sleeping && mode_reg == SMCG_SM_PSAVE);
    c_xstby_wake: cover property (@(posedge clk_sys) cpu_resume && mode_reg == SMCG_SM_XSTBY);
    c_conv_ext: cover property (@(posedge clk_sys) $rose(conv_ext_reg));
endmodule

// File: tb/smcg_top_test.sv
// Self-checking register-level test of the sleep-mode and clock-gating controller.
`timescale 1ns/1ps
module smcg_top_test;
    import smcg_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, wake_pin_need = 8'h81;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, brownout_level_fuses = 2'h0, comparator_input_en;
    logic sleep_instr = 1'b0, global_irq_en = 1'b0, ext_wake = 1'b0, xtal_option = 1'b0;
    logic debug_fuse = 1'b0, cpu_halt, cpu_resume, clk_cpu_en, clk_io_en, clk_conv_en;
    logic [2:0] timer2_interrupt_mask = 3'h0, timer2_event = 3'h0;
    logic main_osc_en, t2_osc_en, t2_sync_clk_en, conv_en, conv_extended, cmp_en, vref_en;
    logic brownout_detector_en, wdt_en;
    logic [7:0] periph_clk_en, periph_reg_en, in_buf_en, converter_input_en;
    logic [31:0] rdat;
    logic [1:0] resp;
    int num_errors = 0, checked = 0;
    smcg_top i_smcg_top (.clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr,
        .global_irq_en, .timer2_interrupt_mask, .timer2_event, .ext_wake, .xtal_option,
        .brownout_level_fuses, .debug_fuse, .wake_pin_need, .cpu_halt, .cpu_resume,
        .clk_cpu_en, .clk_io_en, .clk_conv_en, .main_osc_en, .t2_osc_en, .t2_sync_clk_en,
        .periph_clk_en, .periph_reg_en, .conv_en, .conv_extended, .cmp_en, .vref_en,
        .brownout_detector_en, .wdt_en, .in_buf_en, .converter_input_en,
        .comparator_input_en);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Handshakes are judged at the rising edge itself; the response is taken at that same edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic r;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            r = s_axi_rvalid;
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
        end while (r !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic sleep_in(input logic [2:0] mode);
        wr(SMCG_SLEEP_CTRL_OFS, {28'h0, mode, 1'b1});
        @(posedge clk_sys);
        sleep_instr <= 1'b1;
        @(posedge clk_sys);
        sleep_instr <= 1'b0;
        @(negedge clk_sys);
        chk(cpu_halt, 1'b1);
    endtask
    // Fires a timer2 event or the external wake line and counts falling edges until resume.
    task automatic wake(input logic use_t2, input int exp_n);
        int n;
        n = 0;
        @(posedge clk_sys);
        if (use_t2) timer2_event <= 3'h1;
        else ext_wake <= 1'b1;
        while (n < 200 && cpu_resume !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            @(posedge clk_sys);
            timer2_event <= 3'h0;
        end
        chk(n, exp_n);
        ext_wake <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(cpu_halt, (exp_n >= 200) ? 1'b1 : 1'b0);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        rd(SMCG_STATUS_OFS);
        chk(rdat, 32'h400);
        rd(8'h14);
        chk(resp, SMCG_RESP_SLVERR);
        chk(rdat, 32'h0);
        wr(8'h14, 32'h1);
        chk(resp, SMCG_RESP_SLVERR);
        wr(SMCG_POWER_RED_OFS, 32'hff);
        chk(resp, SMCG_RESP_OKAY);
        rd(SMCG_POWER_RED_OFS);
        chk(rdat, {24'h0, SMCG_PR_MASK});
        chk({periph_clk_en & SMCG_PR_MASK, periph_reg_en & SMCG_PR_MASK}, 16'h0);
        wr(SMCG_POWER_RED_OFS, 32'h0);
        chk(periph_clk_en & SMCG_PR_MASK, SMCG_PR_MASK);
        wr(SMCG_INPUT_DIS_OFS, 32'h3ff);
        chk({comparator_input_en, converter_input_en}, 10'h0);
        wr(SMCG_INPUT_DIS_OFS, 32'h0);
        wr(SMCG_SLEEP_CTRL_OFS, {28'h0, SMCG_SM_PDOWN, 1'b0});
        @(posedge clk_sys);
        sleep_instr <= 1'b1;
        @(posedge clk_sys);
        sleep_instr <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(cpu_halt, 1'b0);
        wr(SMCG_POWER_RED_OFS, 32'h01);
        sleep_in(SMCG_SM_IDLE);
        chk({clk_cpu_en, clk_io_en}, 2'b01);
        chk(periph_clk_en[1:0], 2'b10);
        wake(1'b0, SMCG_IRQ_HALT_CYC + 3);
        wr(SMCG_POWER_RED_OFS, 32'h0);
        wr(SMCG_CONFIG_OFS, 32'h39);
        brownout_level_fuses <= 2'h1;
        xtal_option <= 1'b1;
        timer2_interrupt_mask <= 3'h1;
        // Give the reference its start-up time before anything relies on it.
        repeat (SMCG_STARTUP_CYC) @(posedge clk_sys);
        sleep_in(SMCG_SM_PSAVE);
        chk({t2_osc_en, t2_sync_clk_en, main_osc_en, clk_io_en, clk_conv_en}, 5'h10);
        chk({conv_extended, cmp_en, wdt_en, brownout_detector_en, vref_en, conv_en},
            6'h0f);
        chk(periph_clk_en & SMCG_PR_MASK, 8'h0);
        chk(in_buf_en, wake_pin_need);
        wake(1'b1, 200);
        global_irq_en <= 1'b1;
        wake(1'b1, SMCG_STARTUP_CYC + SMCG_IRQ_HALT_CYC + 1);
        sleep_in(SMCG_SM_XSTBY);
        chk(main_osc_en, 1'b1);
        wake(1'b1, SMCG_STBY_WAKE_CYC + 1);
        sleep_in(SMCG_SM_STBY);
        chk(main_osc_en, 1'b1);
        wake(1'b0, SMCG_STBY_WAKE_CYC + 3);
        xtal_option <= 1'b0;
        sleep_in(SMCG_SM_STBY);
        chk(main_osc_en, 1'b0);
        @(posedge clk_sys);
        debug_fuse <= 1'b1;
        @(negedge clk_sys);
        chk(main_osc_en, 1'b1);
        wake(1'b0, SMCG_STARTUP_CYC + SMCG_IRQ_HALT_CYC + 3);
        conclude();
    end
endmodule
